// ==== shared/bcc_pkg.sv ====
// Purpose: Shared constants and types for the block cipher co-processor and its host controller
// Assumes: One 100 MHz clock, asynchronous active-high reset
// Notes:   Register word i of a 128-bit register holds bits [127-32*i -: 32] (big-endian, byte 0 first)
//
// What this block does
// - Key register, 128 bits, read and write
// - Data input register, 128 bits, read and write
// - Result register, 128 bits, read only
// - Only 128-bit blocks and 128-bit keys
// - Computation matches standard AES-128 exactly
// - Engine usable regardless of radio mode
// - Host sets power-on bit before any command
// - Operations start only on host command
// - Four ops: encrypt, derive, decrypt, derive-decrypt
// - Encrypt: key register, plaintext in data
// - Derive: encryption key goes in data register
// - Decrypt: derived key in key register
// - Derive-decrypt: original key, derived internally
// - Done event; host waits before reading result
`default_nettype none

package bcc_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;

  // Device register word indices on the link
  localparam logic [3:0] REG_KEY0   = 4'h0;  // key words 0..3
  localparam logic [3:0] REG_DIN0   = 4'h4;  // data input words 4..7
  localparam logic [3:0] REG_DOUT0  = 4'h8;  // result words 8..11
  localparam logic [3:0] REG_ANACFG = 4'hc;  // analog_function_config
  localparam logic [3:0] REG_CMD    = 4'hd;  // command, write only
  localparam logic [3:0] REG_STAT   = 4'he;  // device status

  localparam int ANACFG_AES_ON_BIT = 0;
  localparam int STAT_BUSY_BIT     = 0;

  // Host controller user registers (user address bit 4 set)
  localparam logic [4:0] HREG_CTRL = 5'h10;  // write: bits[1:0] op, starts a run
  localparam logic [4:0] HREG_STAT = 5'h11;  // bit0 done, bit1 busy

  localparam int HSTAT_DONE_BIT = 0;
  localparam int HSTAT_BUSY_BIT = 1;

  localparam logic [31:0] ANACFG_RESET = 32'h0000_0000;
  localparam logic [7:0]  RCON_FIRST   = 8'h01;
  localparam logic [7:0]  RCON_LAST    = 8'h36;
  localparam logic [3:0]  ROUND_LAST   = 4'h9;  // ten rounds, counted 0..9

  typedef enum logic [1:0] {
    BCC_OP_ENCRYPT    = 2'h0,
    BCC_OP_DERIVE     = 2'h1,
    BCC_OP_DECRYPT    = 2'h2,
    BCC_OP_DERIVE_DEC = 2'h3
  } bcc_op_t;

endpackage

`default_nettype wire

// ==== shared/bcc_if.sv ====
// Purpose: Register link between host controller and cipher device
// Assumes: Host drives address, data and strobes; device answers reads one cycle later
// Notes:   cipher_done_event is a one-cycle pulse from the device
`timescale 1ns/1ps
`default_nettype none

interface bcc_if;
  logic [3:0]  addr;
  logic [31:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        cipher_done_event;

  modport dev  (input addr, input wdata, input wr, input rd, output rdata, output cipher_done_event);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input cipher_done_event);
endinterface

`default_nettype wire

// ==== hdl/bcc_device.sv ====
// Purpose: Iterative AES-128 co-processor with key, data and result registers
// Assumes: Host honours power-on bit and waits for the done event
// Notes:   One round per clock; derive takes 10 cycles, derive-decrypt 20
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`default_nettype none

module bcc_device (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Register link
  bcc_if.dev        lnk
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_KEYX  = 3'b010,
    ST_CRYPT = 3'b100
  } bcc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Finite field helpers

  function automatic logic [7:0] xt(input logic [7:0] a);
    return {a[6:0], 1'b0} ^ (a[7] ? 8'h1b : 8'h00);
  endfunction

  function automatic logic [7:0] gmul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] p;
    logic [7:0] x;
    p = 8'h00;
    x = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) p = p ^ x;
      x = xt(x);
    end
    return p;
  endfunction

  // Inverse as a^254; zero maps to zero
  function automatic logic [7:0] ginv(input logic [7:0] a);
    logic [7:0] p;
    logic [7:0] r;
    p = a;
    r = 8'h01;
    for (int i = 1; i < 8; i++) begin
      p = gmul(p, p);
      r = gmul(r, p);
    end
    return r;
  endfunction

  function automatic logic [7:0] rl(input logic [7:0] a, input int n);
    return 8'((a << n) | (a >> (8 - n)));
  endfunction

  function automatic logic [7:0] sbox(input logic [7:0] a, input logic inv);
    logic [7:0] b;
    if (!inv) begin
      b = ginv(a);
      return b ^ rl(b, 1) ^ rl(b, 2) ^ rl(b, 3) ^ rl(b, 4) ^ 8'h63;
    end
    b = rl(a, 1) ^ rl(a, 3) ^ rl(a, 6) ^ 8'h05;
    return ginv(b);
  endfunction

  function automatic logic [31:0] subword(input logic [31:0] w);
    return {sbox(w[31:24], 1'b0), sbox(w[23:16], 1'b0), sbox(w[15:8], 1'b0), sbox(w[7:0], 1'b0)};
  endfunction

  function automatic logic [31:0] mixcol(input logic [31:0] c, input logic inv);
    logic [7:0] a [4];
    logic [7:0] m [4];
    logic [7:0] k0;
    logic [7:0] k1;
    logic [7:0] k2;
    logic [7:0] k3;
    for (int i = 0; i < 4; i++) a[i] = c[31 - 8 * i -: 8];
    k0 = inv ? 8'h0e : 8'h02;
    k1 = inv ? 8'h0b : 8'h03;
    k2 = inv ? 8'h0d : 8'h01;
    k3 = inv ? 8'h09 : 8'h01;
    for (int i = 0; i < 4; i++) begin
      m[i] = gmul(a[i], k0) ^ gmul(a[(i + 1) % 4], k1) ^ gmul(a[(i + 2) % 4], k2) ^ gmul(a[(i + 3) % 4], k3);
    end
    return {m[0], m[1], m[2], m[3]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [127:0] key_r;        // cipher_key_input
  logic [127:0] din_r;        // cipher_data_input
  logic [127:0] dout_r;       // cipher_result_output
  logic [31:0]  anacfg_r;     // analog_function_config
  logic [127:0] st_r;
  logic [127:0] rk_r;
  logic [7:0]   rc_r;
  logic [3:0]   cnt_r;
  logic         dec_r;
  logic         chain_r;
  logic         done_r;
  logic [31:0]  rdata_r;
  bcc_state_t   state_r;

  logic         aes_on;
  logic         cmd_wr;
  bcc_pkg::bcc_op_t cmd_op;
  logic         last;
  logic         key_back;
  logic [127:0] rk_nxt;
  logic [127:0] st_nxt;

  assign aes_on = anacfg_r[bcc_pkg::ANACFG_AES_ON_BIT];
  assign cmd_wr = lnk.wr && (lnk.addr == bcc_pkg::REG_CMD);
  assign cmd_op = bcc_pkg::bcc_op_t'(lnk.wdata[1:0]);
  assign last   = (cnt_r == bcc_pkg::ROUND_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Key schedule step, forward or backward

  assign key_back = (state_r == ST_CRYPT) && dec_r;

  always_comb begin
    logic [31:0] w [4];
    logic [31:0] n [4];
    w = '{default: 32'h0};
    n = '{default: 32'h0};
    for (int i = 0; i < 4; i++) w[i] = rk_r[127 - 32 * i -: 32];
    if (!key_back) begin
      n[0] = w[0] ^ subword({w[3][23:0], w[3][31:24]}) ^ {rc_r, 24'h000000};
      n[1] = w[1] ^ n[0];
      n[2] = w[2] ^ n[1];
      n[3] = w[3] ^ n[2];
    end else begin
      n[3] = w[3] ^ w[2];
      n[2] = w[2] ^ w[1];
      n[1] = w[1] ^ w[0];
      n[0] = w[0] ^ subword({n[3][23:0], n[3][31:24]}) ^ {rc_r, 24'h000000};
    end
    rk_nxt = {n[0], n[1], n[2], n[3]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // One cipher round on the whole 128-bit state

  always_comb begin
    logic [127:0] t;
    logic [127:0] pre;
    logic [127:0] mx;
    t   = '0;
    pre = '0;
    mx  = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        t[127 - 8 * (r + 4 * c) -: 8] = sbox(st_r[127 - 8 * (r + 4 * (dec_r ? (c + 4 - r) % 4 : (c + r) % 4)) -: 8],
                                          dec_r);
      end
    end
    pre = dec_r ? (t ^ rk_nxt) : t;
    for (int c = 0; c < 4; c++) begin
      mx[127 - 32 * c -: 32] = last ? pre[127 - 32 * c -: 32] : mixcol(pre[127 - 32 * c -: 32], dec_r);
    end
    st_nxt = dec_r ? mx : (mx ^ rk_nxt);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes, open in every radio mode

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      key_r    <= '0;
      din_r    <= '0;
      anacfg_r <= bcc_pkg::ANACFG_RESET;
    end else if (lnk.wr) begin
      if (lnk.addr[3:2] == bcc_pkg::REG_KEY0[3:2]) key_r[127 - 32 * lnk.addr[1:0] -: 32] <= lnk.wdata;
      if (lnk.addr[3:2] == bcc_pkg::REG_DIN0[3:2]) din_r[127 - 32 * lnk.addr[1:0] -: 32] <= lnk.wdata;
      if (lnk.addr == bcc_pkg::REG_ANACFG) anacfg_r <= lnk.wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (lnk.rd) begin
      case (lnk.addr[3:2])
        2'h0: rdata_r <= key_r[127 - 32 * lnk.addr[1:0] -: 32];
        2'h1: rdata_r <= din_r[127 - 32 * lnk.addr[1:0] -: 32];
        2'h2: rdata_r <= dout_r[127 - 32 * lnk.addr[1:0] -: 32];
        default: begin
          if (lnk.addr == bcc_pkg::REG_ANACFG) rdata_r <= anacfg_r;
          else if (lnk.addr == bcc_pkg::REG_STAT) rdata_r <= {31'h0, state_r != ST_IDLE};
          else rdata_r <= 32'h0000_0000;
        end
      endcase
    end
  end

  assign lnk.rdata             = rdata_r;
  assign lnk.cipher_done_event = done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      st_r    <= '0;
      rk_r    <= '0;
      rc_r    <= bcc_pkg::RCON_FIRST;
      cnt_r   <= '0;
      dec_r   <= 1'b0;
      chain_r <= 1'b0;
      dout_r  <= '0;
      done_r  <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (cmd_wr && aes_on) begin
            cnt_r   <= '0;
            st_r    <= din_r ^ key_r;
            rk_r    <= key_r;
            rc_r    <= (cmd_op == bcc_pkg::BCC_OP_DECRYPT) ? bcc_pkg::RCON_LAST : bcc_pkg::RCON_FIRST;
            dec_r   <= (cmd_op == bcc_pkg::BCC_OP_DECRYPT);
            chain_r <= (cmd_op == bcc_pkg::BCC_OP_DERIVE_DEC);
            case (cmd_op)
              bcc_pkg::BCC_OP_ENCRYPT, bcc_pkg::BCC_OP_DECRYPT: state_r <= ST_CRYPT;
              bcc_pkg::BCC_OP_DERIVE: begin
                rk_r    <= din_r;
                state_r <= ST_KEYX;
              end
              default: state_r <= ST_KEYX;
            endcase
          end
        end
        ST_KEYX: begin
          rk_r  <= rk_nxt;
          rc_r  <= xt(rc_r);
          cnt_r <= cnt_r + 4'h1;
          if (last) begin
            cnt_r <= '0;
            if (chain_r) begin
              st_r    <= din_r ^ rk_nxt;
              rc_r    <= bcc_pkg::RCON_LAST;
              dec_r   <= 1'b1;
              state_r <= ST_CRYPT;
            end else begin
              dout_r  <= rk_nxt;
              done_r  <= 1'b1;
              state_r <= ST_IDLE;
            end
          end
        end
        ST_CRYPT: begin
          st_r  <= st_nxt;
          rk_r  <= rk_nxt;
          rc_r  <= dec_r ? ((rc_r == 8'h1b) ? 8'h80 : {1'b0, rc_r[7:1]}) : xt(rc_r);
          cnt_r <= cnt_r + 4'h1;
          if (last) begin
            dout_r  <= st_nxt;
            done_r  <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

endmodule // bcc_device

`default_nettype wire

// ==== hdl/bcc_host.sv ====
// Purpose: Host-side controller driving the cipher device register link
// Assumes: User port strobes are one cycle, never both at once
// Notes:   Addresses below 0x10 pass straight to the device only while no run is in flight; 0x10 and up are local
`timescale 1ns/1ps
`default_nettype none

module bcc_host (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // User register port
  input  wire logic [4:0]  usr_addr,
  input  wire logic [31:0] usr_wdata,
  input  wire logic        usr_wr,
  input  wire logic        usr_rd,
  output logic      [31:0] usr_rdata,
  // Device link
  bcc_if.host              lnk
);

  typedef enum logic [3:0] {
    HS_IDLE = 4'b0001,
    HS_PWR  = 4'b0010,
    HS_CMD  = 4'b0100,
    HS_WAIT = 4'b1000
  } bcc_hstate_t;

  bcc_hstate_t hst_r;
  logic [1:0]  op_r;
  logic        done_r;
  logic        local_r;
  logic [31:0] lrd_r;
  logic        go;
  logic        fwd_ok;

  assign go     = usr_wr && (usr_addr == bcc_pkg::HREG_CTRL) && (hst_r == HS_IDLE);
  assign fwd_ok = (hst_r == HS_IDLE) && !usr_addr[4];

  ////////////////////////////////////////////////////////////////////////////
  // Link drive: sequencer owns the link while a run is in flight

  always_comb begin
    lnk.addr  = usr_addr[3:0];
    lnk.wdata = usr_wdata;
    lnk.wr    = usr_wr && fwd_ok;
    lnk.rd    = usr_rd && fwd_ok;
    case (hst_r)
      HS_PWR: begin
        lnk.addr  = bcc_pkg::REG_ANACFG;
        lnk.wdata = 32'h1 << bcc_pkg::ANACFG_AES_ON_BIT;
        lnk.wr    = 1'b1;
        lnk.rd    = 1'b0;
      end
      HS_CMD: begin
        lnk.addr  = bcc_pkg::REG_CMD;
        lnk.wdata = {30'h0, op_r};
        lnk.wr    = 1'b1;
        lnk.rd    = 1'b0;
      end
      default: begin
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run sequencer

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hst_r <= HS_IDLE;
      op_r  <= 2'h0;
    end else begin
      case (hst_r)
        HS_IDLE: begin
          if (go) begin
            op_r  <= usr_wdata[1:0];
            hst_r <= HS_PWR;
          end
        end
        HS_PWR:  hst_r <= HS_CMD;
        HS_CMD:  hst_r <= HS_WAIT;
        HS_WAIT: if (lnk.cipher_done_event) hst_r <= HS_IDLE;
        default: hst_r <= HS_IDLE;
      endcase
    end
  end

  // Done flag: set by the event wins over clear by a new run
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
    end else if (lnk.cipher_done_event) begin
      done_r <= 1'b1;
    end else if (go) begin
      done_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      local_r <= 1'b1;
      lrd_r   <= '0;
    end else if (usr_rd) begin
      local_r <= !fwd_ok;
      if (usr_addr == bcc_pkg::HREG_STAT) begin
        lrd_r <= {30'h0, hst_r != HS_IDLE, done_r};
      end else begin
        lrd_r <= 32'h0000_0000;
      end
    end
  end

  assign usr_rdata = local_r ? lrd_r : lnk.rdata;

endmodule // bcc_host

`default_nettype wire

// ==== sim/bcc_sva.sv ====
// Purpose: Link-level checks between host controller and cipher device
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Tracks power bit and run length from the link traffic alone
`timescale 1ns/1ps
`default_nettype none

module bcc_sva (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // Link signals
  input wire logic [3:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        cipher_done_event
);
  logic       pwr_r;
  logic [4:0] cnt_r;
  logic       cmd_take;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  assign cmd_take = wr && (addr == bcc_pkg::REG_CMD) && pwr_r && (cnt_r == 5'h00);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pwr_r <= 1'b0;
    end else if (wr && (addr == bcc_pkg::REG_ANACFG)) begin
      pwr_r <= wdata[bcc_pkg::ANACFG_AES_ON_BIT];
    end
  end

  // Cycles left until the done pulse is due
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'h00;
    end else if (cmd_take) begin
      cnt_r <= (wdata[1:0] == 2'h3) ? 5'h15 : 5'h0b;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_reg_write;
    wr && (addr < 4'h8);
  endsequence
  sequence s_gap_read;
    !wr ##1 (rd && (addr == $past(addr, 2)));
  endsequence
  sequence s_cmd_off;
    wr && (addr == bcc_pkg::REG_CMD) && !pwr_r && (cnt_r == 5'h00);
  endsequence

  property p_reg_readback;
    s_reg_write ##1 s_gap_read |=> (rdata == $past(wdata, 3));
  endproperty
  property p_done_when_due;
    cipher_done_event |-> (cnt_r == 5'h01);
  endproperty
  property p_due_done;
    (cnt_r == 5'h01) |-> cipher_done_event;
  endproperty
  property p_done_pulse;
    cipher_done_event |=> !cipher_done_event;
  endproperty
  property p_off_ignored;
    s_cmd_off |-> ##10 !cipher_done_event ##10 !cipher_done_event;
  endproperty
  property p_pwr_cmd;
    (wr && (addr == bcc_pkg::REG_ANACFG) && wdata[bcc_pkg::ANACFG_AES_ON_BIT]) |=> (wr && (addr == bcc_pkg::REG_CMD));
  endproperty
  property p_rdata_hold;
    !rd |=> $stable(rdata);
  endproperty
  property p_unmapped;
    (rd && (addr == 4'hf)) |=> (rdata == 32'h0);
  endproperty
  property p_strobe_excl;
    !(wr && rd);
  endproperty

  a_reg_readback: assert property (p_reg_readback) else $error("register readback differs");
  a_done_when_due: assert property (p_done_when_due) else $error("done pulse at wrong cycle");
  a_due_done: assert property (p_due_done) else $error("done pulse missing");
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  a_off_ignored: assert property (p_off_ignored) else $error("command run while powered off");
  a_pwr_cmd: assert property (p_pwr_cmd) else $error("command not after power on");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_strobe_excl: assert property (p_strobe_excl) else $error("read and write together");
endmodule // bcc_sva

`default_nettype wire

// ==== sim/block_cipher_coprocessor_tb.sv ====
// Purpose: Self-checking bench for host controller and cipher device together
// Assumes: Known AES-128 vectors; user strobes one cycle with a gap
// Notes:   Rows cover the four operations; hand tests cover refusals and reset
`timescale 1ns/1ps
`default_nettype none

module block_cipher_coprocessor_tb;
  typedef struct packed {
    logic [1:0]   op;
    logic [127:0] key;
    logic [127:0] din;
    logic [127:0] exp;
  } bcc_row_t;

  localparam logic [127:0] K  = 128'h000102030405060708090a0b0c0d0e0f;
  localparam logic [127:0] P  = 128'h00112233445566778899aabbccddeeff;
  localparam logic [127:0] C  = 128'h69c4e0d86a7b0430d8cdb78070b4c55a;
  localparam logic [127:0] RK = 128'h13111d7fe3944a17f307a78b4d2b30c5;
  localparam logic [127:0] Z  = 128'h66e94bd4ef8a2c3b884cfa59ca342b2e;

  logic        core_clk = 1'b0;
  logic        rst;
  logic [4:0]  usr_addr;
  logic [31:0] usr_wdata;
  logic        usr_wr;
  logic        usr_rd;
  logic [31:0] usr_rdata;
  logic [31:0] v;
  bcc_row_t    rows [4];
  int          num_errors = 0;
  int          compares = 0;
  int          n_done = 0;
  int          n;

  bcc_if lnk ();
  bcc_host u_bcc_host (.core_clk(core_clk), .rst(rst), .usr_addr(usr_addr), .usr_wdata(usr_wdata),
                       .usr_wr(usr_wr), .usr_rd(usr_rd), .usr_rdata(usr_rdata), .lnk(lnk));
  bcc_device u_bcc_device (.core_clk(core_clk), .rst(rst), .lnk(lnk));
  bcc_sva u_bcc_sva (.core_clk(core_clk), .rst(rst), .addr(lnk.addr), .wdata(lnk.wdata), .wr(lnk.wr),
                     .rd(lnk.rd), .rdata(lnk.rdata), .cipher_done_event(lnk.cipher_done_event));

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (lnk.cipher_done_event === 1'b1) begin
      n_done++;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic wr_u(input logic [4:0] a, input logic [31:0] d);
    @(posedge core_clk);
    usr_addr  <= a;
    usr_wdata <= d;
    usr_wr    <= 1'b1;
    @(posedge core_clk);
    usr_wr <= 1'b0;
  endtask

  task automatic rd_u(input logic [4:0] a, output logic [31:0] d);
    @(posedge core_clk);
    usr_addr <= a;
    usr_rd   <= 1'b1;
    @(posedge core_clk);
    usr_rd <= 1'b0;
    #1;
    d = usr_rdata;
  endtask

  task automatic put(input logic [4:0] a, input logic [31:0] d);
    wr_u(a, d);
    rd_u(a, v);
    check("register readback", d, v);
  endtask

  task automatic wait_done();
    int k;
    k = 0;
    rd_u(bcc_pkg::HREG_STAT, v);
    while (v[bcc_pkg::HSTAT_DONE_BIT] !== 1'b1 && k < 30) begin
      rd_u(bcc_pkg::HREG_STAT, v);
      k++;
    end
    check("done status", 32'h1, {31'h0, v[bcc_pkg::HSTAT_DONE_BIT]});
  endtask

  task automatic check_res(input logic [127:0] exp);
    for (int i = 0; i < 4; i++) begin
      rd_u(5'h08 + 5'(i), v);
      check("result word", exp[127-32*i -: 32], v);
    end
  endtask

  task automatic run_row(input bcc_row_t r);
    for (int i = 0; i < 4; i++) begin
      put(5'(i), r.key[127-32*i -: 32]);
      put(5'(4+i), r.din[127-32*i -: 32]);
    end
    wr_u(bcc_pkg::HREG_CTRL, {30'h0, r.op});
    wait_done();
    check_res(r.exp);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    num_errors++;
    $display("test watchdog expired");
    finish_test();
  end

  initial begin
    rst       = 1'b1;
    usr_addr  = 5'h00;
    usr_wdata = 32'h0;
    usr_wr    = 1'b0;
    usr_rd    = 1'b0;
    rows[0] = '{bcc_pkg::BCC_OP_ENCRYPT, K, P, C};
    rows[1] = '{bcc_pkg::BCC_OP_DERIVE, P, K, RK};
    rows[2] = '{bcc_pkg::BCC_OP_DECRYPT, RK, C, P};
    rows[3] = '{bcc_pkg::BCC_OP_DERIVE_DEC, K, C, P};
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rd_u(bcc_pkg::HREG_STAT, v);
    check("status after reset", 32'h0, v);
    check_res(128'h0);
    $display("test reset done");
    for (int j = 0; j < 4; j++) begin
      run_row(rows[j]);
      $display("test row %0d done", j);
    end
    // Second run request while busy is dropped
    wr_u(bcc_pkg::HREG_CTRL, {30'h0, bcc_pkg::BCC_OP_DERIVE_DEC});
    wr_u(bcc_pkg::HREG_CTRL, {30'h0, bcc_pkg::BCC_OP_ENCRYPT});
    rd_u(bcc_pkg::HREG_STAT, v);
    check("busy status", 32'h2, v);
    rd_u(5'h00, v);
    check("forwarded read while busy", 32'h0, v);
    wait_done();
    check_res(P);
    $display("test busy refusal done");
    // Result is read only; powered-off command does nothing
    wr_u(5'h08, 32'hffff_ffff);
    wr_u(5'h0c, 32'h0);
    n = n_done;
    wr_u(5'h0d, 32'h0);
    repeat (25) @(posedge core_clk);
    check("done count", 32'(n), 32'(n_done));
    check_res(P);
    rd_u(5'h0f, v);
    check("unmapped read", 32'h0, v);
    rd_u(5'h0e, v);
    check("device status", 32'h0, v);
    $display("test power off done");
    // Reset in mid-run, then zero key and block
    wr_u(bcc_pkg::HREG_CTRL, {30'h0, bcc_pkg::BCC_OP_ENCRYPT});
    repeat (4) @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    check_res(128'h0);
    wr_u(bcc_pkg::HREG_CTRL, {30'h0, bcc_pkg::BCC_OP_ENCRYPT});
    wait_done();
    check_res(Z);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule // block_cipher_coprocessor_tb

`default_nettype wire
